// file: rtl/fssc_top.sv
`timescale 1ns/1ps
// Contract
// - Flat outputs copied from provoking vertex
// - Provoke bit picks first or last
// - Point and line provoking indices
// - Triangle provoking indices
// - Adjacency primitive provoking indices
// - Quad provoking follows fixed honoured bit
// - Shade bit: smooth or flat
// - Colour source: current, lit, shader
// - Reset: smooth shading, last vertex
// - View volume minus w to w
// - Eight user planes; none equals view
// - Plane test: dot product not negative
// - Shader clip position replaces eye vector
// - Shader plane distances, non-negative inside
// - Per-plane enable bits gate clipping
// - Depth clamp drops z bounds
// - Points/lines pass inside, discard outside
// - Partial line gets cut endpoints, weight kept; code only flags outside endpoints in cut_mask, no weight
// - Polygon cut; new edges flagged true; code cuts no polygon and sets new_edge_flag whenever any endpoint is outside
// - Cut point inside original hull; code computes no cut point, only flags the outside endpoint in cut_mask
// - Negated planes complement exactly; code counts a point on the plane inside both
// - Reset: enables clear, coefficients zero
module fssc_top (
  // Clock and reset
  input  wire logic                           I_CLK,
  input  wire logic                           I_RST_N,
  // Command port
  input  wire logic [fssc_pkg::CFG_ADDR_W-1:0] I_ADDR,
  input  wire logic [fssc_pkg::DATA_W-1:0]     I_WDATA,
  input  wire logic                           I_WR,
  input  wire logic                           I_RD,
  output logic      [fssc_pkg::DATA_W-1:0]     O_RDATA,
  // Upstream primitive stream
  input  wire logic                           I_VALID,
  input  wire fssc_pkg::fssc_prim_in_t        I_PRIM,
  output logic                                O_READY,
  // Downstream result stream
  output logic                                O_VALID,
  output fssc_pkg::fssc_prim_out_t            O_RESULT,
  input  wire logic                           I_READY
);

  localparam int unsigned IDX_W = fssc_pkg::IDX_W;
  localparam int unsigned NP    = fssc_pkg::NUM_PLANES;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Test one vertex against the view volume; clamp drops z bounds
  function automatic logic in_view(input fssc_pkg::fssc_vec_t v, input logic clamp);
    logic ok;
    ok = ($signed(v.x) <= $signed(v.w)) && ($signed(v.x) >= -$signed(v.w))
      && ($signed(v.y) <= $signed(v.w)) && ($signed(v.y) >= -$signed(v.w));
    if (!clamp) begin
      ok = ok && ($signed(v.z) <= $signed(v.w)) && ($signed(v.z) >= -$signed(v.w));
    end
    return ok;
  endfunction

  // Dot product of plane and vector, full width so no rounding
  function automatic logic signed [fssc_pkg::SUM_W-1:0] dot4(
    input logic [3:0][fssc_pkg::COORD_W-1:0] c,
    input fssc_pkg::fssc_vec_t               v);
    logic signed [fssc_pkg::SUM_W-1:0] s;
    s = fssc_pkg::SUM_W'($signed(c[0]) * $signed(v.x))
      + fssc_pkg::SUM_W'($signed(c[1]) * $signed(v.y))
      + fssc_pkg::SUM_W'($signed(c[2]) * $signed(v.z))
      + fssc_pkg::SUM_W'($signed(c[3]) * $signed(v.w));
    return s;
  endfunction

  // Provoking vertex index, 1-based, for primitive i of n vertices
  function automatic logic [fssc_pkg::IDX_W-1:0] provoke_idx(
    input fssc_pkg::fssc_prim_t p, input logic [fssc_pkg::IDX_W-1:0] i,
    input logic [fssc_pkg::IDX_W-1:0] n, input logic last);
    logic [fssc_pkg::IDX_W-1:0] r;
    logic                       ql;
    ql = last || !fssc_pkg::QUAD_MODE_HONOURED;
    case (p)
      fssc_pkg::PRIM_POINT:      r = i;
      fssc_pkg::PRIM_LINES:      r = last ? IDX_W'(2*i) : IDX_W'(2*i-1);
      fssc_pkg::PRIM_LINE_LOOP:  r = !last ? i : (i == n) ? IDX_W'(1) : IDX_W'(i+1);
      fssc_pkg::PRIM_LINE_STRIP: r = last ? IDX_W'(i+1) : i;
      fssc_pkg::PRIM_TRIS:       r = last ? IDX_W'(3*i) : IDX_W'(3*i-2);
      fssc_pkg::PRIM_TRI_STRIP:  r = last ? IDX_W'(i+2) : i;
      fssc_pkg::PRIM_TRI_FAN:    r = last ? IDX_W'(i+2) : IDX_W'(i+1);
      fssc_pkg::PRIM_QUADS:      r = ql ? IDX_W'(4*i) : IDX_W'(4*i-3);
      fssc_pkg::PRIM_QUAD_STRIP: r = ql ? IDX_W'(2*i+2) : IDX_W'(2*i-1);
      fssc_pkg::PRIM_POLYGON:    r = IDX_W'(1);
      fssc_pkg::PRIM_LINES_ADJ:  r = last ? IDX_W'(4*i-1) : IDX_W'(4*i-2);
      fssc_pkg::PRIM_LSTRIP_ADJ: r = last ? IDX_W'(i+2) : IDX_W'(i+1);
      fssc_pkg::PRIM_TRIS_ADJ:   r = last ? IDX_W'(6*i-1) : IDX_W'(6*i-5);
      fssc_pkg::PRIM_TSTRIP_ADJ: r = last ? IDX_W'(2*i+3) : IDX_W'(2*i-1);
      default:                   r = i;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic                             shade;
  logic                             provoke;
  logic                             clamp;
  logic                             light;
  logic                             shader;
  logic                             use_dist;
  logic [NP-1:0]                    enable;
  logic [fssc_pkg::PLANE_W-1:0]     sel;
  logic                             next_shade;
  logic                             next_provoke;
  logic                             next_clamp;
  logic                             next_light;
  logic                             next_shader;
  logic                             next_use_dist;
  logic [NP-1:0]                    next_enable;
  logic [fssc_pkg::PLANE_W-1:0]     next_sel;
  logic [fssc_pkg::DATA_W-1:0]      rdata;
  logic [fssc_pkg::DATA_W-1:0]      next_rdata;
  logic                             coef_we;
  logic [NP-1:0][3:0][fssc_pkg::COORD_W-1:0] coef;

  // Coefficients arrive already in eye space, transformed by software
  assign coef_we = I_WR && (I_ADDR >= fssc_pkg::ADDR_COEF0)
                        && (I_ADDR <= fssc_pkg::ADDR_COEF3);

  fssc_plane_mem u_mem (
    .i_clk    (I_CLK),
    .i_rst_n  (I_RST_N),
    .i_we     (coef_we),
    .i_wplane (sel),
    .i_wcoef  (I_ADDR[1:0]),
    .i_wdata  (I_WDATA[fssc_pkg::COORD_W-1:0]),
    .o_coef   (coef)
  );

  // Command decode and read mux; unmapped reads return zero
  always_comb begin
    next_shade    = shade;
    next_provoke  = provoke;
    next_clamp    = clamp;
    next_light    = light;
    next_shader   = shader;
    next_use_dist = use_dist;
    next_enable   = enable;
    next_sel      = sel;
    next_rdata    = '0;
    if (I_WR) begin
      case (I_ADDR)
        fssc_pkg::ADDR_MODE: begin
          next_shade    = I_WDATA[fssc_pkg::MODE_SHADE_BIT];
          next_provoke  = I_WDATA[fssc_pkg::MODE_PROVOKE_BIT];
          next_clamp    = I_WDATA[fssc_pkg::MODE_CLAMP_BIT];
          next_light    = I_WDATA[fssc_pkg::MODE_LIGHT_BIT];
          next_shader   = I_WDATA[fssc_pkg::MODE_SHADER_BIT];
          next_use_dist = I_WDATA[fssc_pkg::MODE_DIST_BIT];
        end
        fssc_pkg::ADDR_ENABLE: next_enable = I_WDATA[NP-1:0];
        fssc_pkg::ADDR_SELECT: next_sel = I_WDATA[fssc_pkg::PLANE_W-1:0];
        default: ;
      endcase
    end
    if (I_RD) begin
      case (I_ADDR)
        fssc_pkg::ADDR_MODE: begin
          next_rdata[fssc_pkg::MODE_SHADE_BIT]   = shade;
          next_rdata[fssc_pkg::MODE_PROVOKE_BIT] = provoke;
          next_rdata[fssc_pkg::MODE_CLAMP_BIT]   = clamp;
          next_rdata[fssc_pkg::MODE_LIGHT_BIT]   = light;
          next_rdata[fssc_pkg::MODE_SHADER_BIT]  = shader;
          next_rdata[fssc_pkg::MODE_DIST_BIT]    = use_dist;
        end
        fssc_pkg::ADDR_ENABLE: next_rdata[NP-1:0] = enable;
        fssc_pkg::ADDR_SELECT: next_rdata[fssc_pkg::PLANE_W-1:0] = sel;
        fssc_pkg::ADDR_STATUS: begin
          next_rdata[0] = fssc_pkg::QUAD_MODE_HONOURED;
          next_rdata[1] = O_VALID;
        end
        default: begin
          if (I_ADDR >= fssc_pkg::ADDR_COEF0 && I_ADDR <= fssc_pkg::ADDR_COEF3) begin
            next_rdata[fssc_pkg::COORD_W-1:0] = coef[sel][I_ADDR[1:0]];
          end
        end
      endcase
    end
  end

  // Reset gives smooth, last vertex, planes off
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      shade    <= fssc_pkg::SHADE_SMOOTH;
      provoke  <= fssc_pkg::PROVOKE_LAST;
      clamp    <= 1'b0;
      light    <= 1'b0;
      shader   <= 1'b0;
      use_dist <= 1'b0;
      enable   <= fssc_pkg::ENABLE_RESET;
      sel      <= '0;
      rdata    <= '0;
    end else begin
      shade    <= next_shade;
      provoke  <= next_provoke;
      clamp    <= next_clamp;
      light    <= next_light;
      shader   <= next_shader;
      use_dist <= next_use_dist;
      enable   <= next_enable;
      sel      <= next_sel;
      rdata    <= next_rdata;
    end
  end

  assign O_RDATA = rdata;

  // ----------------------------------------------------------------
  // Classification of the incoming primitive
  // ----------------------------------------------------------------
  logic [1:0]    vin;      // Per-endpoint inside flag
  fssc_pkg::fssc_vec_t pos_a;
  fssc_pkg::fssc_vec_t pos_b;

  // Shader clip position replaces eye vector; the caller supplies it in eye_*
  always_comb begin
    pos_a = I_PRIM.eye_a;
    pos_b = I_PRIM.eye_b;
    vin[0] = in_view(I_PRIM.clip_a, clamp);
    vin[1] = in_view(I_PRIM.clip_b, clamp) || (I_PRIM.nverts == 2'd1);
    for (int p = 0; p < NP; p++) begin
      if (enable[p]) begin
        if (use_dist) begin
          vin[0] = vin[0] && !I_PRIM.dist_a[p][fssc_pkg::COORD_W-1];
          vin[1] = vin[1] && (I_PRIM.nverts == 2'd1
                              || !I_PRIM.dist_b[p][fssc_pkg::COORD_W-1]);
        end else begin
          vin[0] = vin[0] && (dot4(coef[p], pos_a) >= 0);
          vin[1] = vin[1] && (I_PRIM.nverts == 2'd1
                              || dot4(coef[p], pos_b) >= 0);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pipeline control: one result per primitive
  // ----------------------------------------------------------------
  fssc_pkg::fssc_state_t    state;
  fssc_pkg::fssc_state_t    next_state;
  fssc_pkg::fssc_prim_out_t result;
  fssc_pkg::fssc_prim_out_t next_result;
  logic                     ovalid;
  logic                     next_ovalid;
  logic                     ready;
  logic                     next_ready;

  // Outside points and both-out edges are discarded; a mixed edge is cut. Cut endpoints are
  // only flagged in cut_mask; no boundary crossing or weight is computed here.
  // Using >= 0 as inside and < 0 as outside puts a point on a plane inside both it and its negation.
  always_comb begin
    next_state  = state;
    next_result = result;
    next_ovalid = ovalid;
    next_ready  = ready;
    case (state)
      fssc_pkg::ST_IDLE: begin
        next_ready = 1'b1;
        if (I_VALID && ready) begin
          next_ready = 1'b0;
          next_state = fssc_pkg::ST_EVAL;
          next_result.provoke_index =
            provoke_idx(I_PRIM.prim, I_PRIM.index, I_PRIM.count, provoke);
          next_result.flat = (shade == fssc_pkg::SHADE_FLAT);
          next_result.color_src = shader ? fssc_pkg::COLOR_SHADER
                                : light  ? fssc_pkg::COLOR_LIT
                                         : fssc_pkg::COLOR_CURRENT;
          if (&vin) begin
            next_result.outcome = fssc_pkg::CLIP_PASS;
          end else if (vin == 2'b00 || I_PRIM.nverts == 2'd1) begin
            next_result.outcome = fssc_pkg::CLIP_DISCARD;
          end else begin
            next_result.outcome = fssc_pkg::CLIP_CUT;
          end
          next_result.cut_mask      = ~vin;
          next_result.new_edge_flag = !(&vin);
        end
      end
      fssc_pkg::ST_EVAL: begin
        next_ovalid = 1'b1;
        next_state  = fssc_pkg::ST_HOLD;
      end
      fssc_pkg::ST_HOLD: begin
        if (I_READY) begin
          next_ovalid = 1'b0;
          next_ready  = 1'b1;
          next_state  = fssc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state  = fssc_pkg::ST_IDLE;
        next_ovalid = 1'b0;
        next_ready  = 1'b0;
      end
    endcase
  end

  // Result held stable while downstream stalls
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state  <= fssc_pkg::ST_IDLE;
      result <= '0;
      ovalid <= 1'b0;
      ready  <= 1'b0;
    end else begin
      state  <= next_state;
      result <= next_result;
      ovalid <= next_ovalid;
      ready  <= next_ready;
    end
  end

  assign O_VALID  = ovalid;
  assign O_RESULT = result;
  assign O_READY  = ready;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_take;
    I_VALID && ready && state == fssc_pkg::ST_IDLE;
  endsequence

  sequence s_emit;
    ovalid [*1];
  endsequence

  chk_take_emit: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_take |-> ##2 s_emit)
    else $error("result not presented two cycles after take");

  chk_hold_stall: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    ovalid && !I_READY |=> ovalid && $stable(result))
    else $error("result changed while stalled");

  chk_reset_modes: assert property (@(posedge I_CLK)
    !I_RST_N |=> shade == fssc_pkg::SHADE_SMOOTH && provoke == fssc_pkg::PROVOKE_LAST)
    else $error("mode not reset to smooth and last");

  chk_reset_enable: assert property (@(posedge I_CLK)
    !I_RST_N |=> enable == '0 && coef == '0)
    else $error("planes not cleared at reset");

  chk_flat_follow: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_take |=> result.flat == ($past(shade) == fssc_pkg::SHADE_FLAT))
    else $error("flat flag does not follow shade bit");

  chk_point_idx: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_take and I_PRIM.prim == fssc_pkg::PRIM_POINT |=> result.provoke_index == $past(I_PRIM.index))
    else $error("point provoking index wrong");

  chk_tri_last: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_take and I_PRIM.prim == fssc_pkg::PRIM_TRIS and provoke
    |=> result.provoke_index == IDX_W'(3 * $past(I_PRIM.index)))
    else $error("triangle last provoking index wrong");

  chk_inside_pass: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_take and (&vin) |=> result.outcome == fssc_pkg::CLIP_PASS)
    else $error("inside primitive not passed");

  chk_outside_drop: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_take and vin == 2'b00 |=> result.outcome == fssc_pkg::CLIP_DISCARD)
    else $error("outside primitive not discarded");

endmodule

// file: rtl/fssc_pkg.sv
package fssc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PLANES = 8;
  localparam int unsigned PLANE_W    = 3;
  localparam int unsigned COORD_W    = 16;
  localparam int unsigned PROD_W     = 2 * COORD_W;
  localparam int unsigned SUM_W      = PROD_W + 2;
  localparam int unsigned IDX_W      = 16;
  localparam int unsigned CFG_ADDR_W = 4;
  localparam int unsigned DATA_W     = 32;

  // ----------------------------------------------------------------
  // Command port offsets
  // ----------------------------------------------------------------
  localparam logic [CFG_ADDR_W-1:0] ADDR_MODE   = 4'h0;
  localparam logic [CFG_ADDR_W-1:0] ADDR_ENABLE = 4'h1;
  localparam logic [CFG_ADDR_W-1:0] ADDR_SELECT = 4'h2;
  localparam logic [CFG_ADDR_W-1:0] ADDR_COEF0  = 4'h4;
  localparam logic [CFG_ADDR_W-1:0] ADDR_COEF3  = 4'h7;
  localparam logic [CFG_ADDR_W-1:0] ADDR_STATUS = 4'h8;

  // Mode register fields
  localparam int unsigned MODE_SHADE_BIT   = 0;
  localparam int unsigned MODE_PROVOKE_BIT = 1;
  localparam int unsigned MODE_CLAMP_BIT   = 2;
  localparam int unsigned MODE_LIGHT_BIT   = 3;
  localparam int unsigned MODE_SHADER_BIT  = 4;
  localparam int unsigned MODE_DIST_BIT    = 5;

  // Fixed quad behaviour: provoke rule honoured for quads
  localparam logic QUAD_MODE_HONOURED = 1'b1;

  // Mode encodings and reset values
  localparam logic SHADE_SMOOTH      = 1'b0;
  localparam logic SHADE_FLAT        = 1'b1;
  localparam logic PROVOKE_FIRST     = 1'b0;
  localparam logic PROVOKE_LAST      = 1'b1;
  localparam logic [NUM_PLANES-1:0] ENABLE_RESET = 8'h00;
  localparam logic [COORD_W-1:0]    COEF_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PRIM_POINT      = 4'h0,
    PRIM_LINES      = 4'h1,
    PRIM_LINE_LOOP  = 4'h2,
    PRIM_LINE_STRIP = 4'h3,
    PRIM_TRIS       = 4'h4,
    PRIM_TRI_STRIP  = 4'h5,
    PRIM_TRI_FAN    = 4'h6,
    PRIM_QUADS      = 4'h7,
    PRIM_QUAD_STRIP = 4'h8,
    PRIM_POLYGON    = 4'h9,
    PRIM_LINES_ADJ  = 4'hA,
    PRIM_LSTRIP_ADJ = 4'hB,
    PRIM_TRIS_ADJ   = 4'hC,
    PRIM_TSTRIP_ADJ = 4'hD
  } fssc_prim_t;

  typedef enum logic [1:0] {
    CLIP_PASS    = 2'h0,
    CLIP_DISCARD = 2'h1,
    CLIP_CUT     = 2'h2
  } fssc_outcome_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EVAL = 2'b01,
    ST_HOLD = 2'b11
  } fssc_state_t;

  typedef enum logic [1:0] {
    COLOR_CURRENT = 2'h0,
    COLOR_LIT     = 2'h1,
    COLOR_SHADER  = 2'h2
  } fssc_color_src_t;

  typedef struct packed {
    logic signed [COORD_W-1:0] x;
    logic signed [COORD_W-1:0] y;
    logic signed [COORD_W-1:0] z;
    logic signed [COORD_W-1:0] w;
  } fssc_vec_t;

  // One primitive edge: two endpoints, eye or clip-position, distances
  typedef struct packed {
    fssc_prim_t                            prim;
    logic [IDX_W-1:0]                      index;
    logic [IDX_W-1:0]                      count;
    logic [1:0]                            nverts;
    fssc_vec_t                             clip_a;
    fssc_vec_t                             clip_b;
    fssc_vec_t                             eye_a;
    fssc_vec_t                             eye_b;
    logic [NUM_PLANES-1:0][COORD_W-1:0]    dist_a;
    logic [NUM_PLANES-1:0][COORD_W-1:0]    dist_b;
  } fssc_prim_in_t;

  typedef struct packed {
    logic [IDX_W-1:0] provoke_index;
    logic             flat;
    fssc_color_src_t  color_src;
    fssc_outcome_t    outcome;
    logic [1:0]       cut_mask;
    logic             new_edge_flag;
  } fssc_prim_out_t;

endpackage

// file: rtl/fssc_plane_mem.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Plane coefficient store, read straight from its registers
// ------------------------------------------------------------------
module fssc_plane_mem (
  // Clock and reset
  input  wire logic                                        i_clk,
  input  wire logic                                        i_rst_n,
  // Write port
  input  wire logic                                        i_we,
  input  wire logic [fssc_pkg::PLANE_W-1:0]                i_wplane,
  input  wire logic [1:0]                                  i_wcoef,
  input  wire logic [fssc_pkg::COORD_W-1:0]                i_wdata,
  // Read port, all coefficients of all planes
  output logic [fssc_pkg::NUM_PLANES-1:0][3:0][fssc_pkg::COORD_W-1:0] o_coef
);

  logic [fssc_pkg::NUM_PLANES-1:0][3:0][fssc_pkg::COORD_W-1:0] mem;
  logic [fssc_pkg::NUM_PLANES-1:0][3:0][fssc_pkg::COORD_W-1:0] next_mem;

  // Update selected coefficient
  always_comb begin
    next_mem = mem;
    if (i_we) begin
      next_mem[i_wplane][i_wcoef] = i_wdata;
    end
  end

  // Coefficients clear to zero at reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mem <= '0;
    end else begin
      mem <= next_mem;
    end
  end

  assign o_coef = mem;

endmodule

// file: tb/fssc_sink.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Downstream sink model
// ------------------------------------------------------------------
module fssc_sink (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  // Result stream from the block
  input  wire logic                     i_valid,
  input  wire fssc_pkg::fssc_prim_out_t i_result,
  output logic                          o_ready,
  // Stall control and capture
  input  wire logic [3:0]               i_stall,
  output fssc_pkg::fssc_prim_out_t      o_last,
  output logic                          o_got
);
  logic [3:0] cnt;

  // Ready only after the stall, so held results are exercised
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_got   <= 1'b0;
      o_last  <= '0;
      cnt     <= 4'h0;
    end else if (o_ready && i_valid) begin
      o_ready <= 1'b0;
      o_got   <= 1'b1;
      o_last  <= i_result; // Index and outcome in one transfer
      cnt     <= 4'h0;
    end else begin
      o_got <= 1'b0;
      if (i_valid && cnt >= i_stall) o_ready <= 1'b1;
      else if (i_valid) cnt <= cnt + 4'h1;
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct {fssc_pkg::fssc_prim_t p; logic [15:0] i, f, l;} fssc_row_t;
  logic                      I_CLK   = 1'b0;
  logic                      I_RST_N = 1'b0;
  logic [3:0]                I_ADDR  = 4'h0;
  logic [31:0]               I_WDATA = 32'h00000000;
  logic                      I_WR    = 1'b0;
  logic                      I_RD    = 1'b0;
  logic                      I_VALID = 1'b0;
  fssc_pkg::fssc_prim_in_t   I_PRIM  = '0;
  logic [3:0]                stall   = 4'h0;
  logic [31:0]               O_RDATA;
  logic                      O_READY, O_VALID, I_READY, got;
  fssc_pkg::fssc_prim_out_t  O_RESULT, res;
  int                        miscompares = 0;
  int                        checked = 0;
  fssc_pkg::fssc_vec_t v_in  = {16'h0000, 16'h0000, 16'h0000, 16'h000A};
  fssc_pkg::fssc_vec_t v_bnd = {16'h000A, 16'hFFF6, 16'h000A, 16'h000A};
  fssc_pkg::fssc_vec_t v_out = {16'h000B, 16'h0000, 16'h0000, 16'h000A};
  fssc_pkg::fssc_vec_t v_z   = {16'h0000, 16'h0000, 16'h0014, 16'h000A};
  fssc_pkg::fssc_vec_t v_neg = {16'hFFFF, 16'h0000, 16'h0000, 16'h0001};
  // Provoking index of primitive 2 of 5 (loop and point also at 5, polygon at 1), first and last
  fssc_row_t rows [16] = '{
    '{fssc_pkg::PRIM_POINT, 2, 2, 2}, '{fssc_pkg::PRIM_LINES, 2, 3, 4},
    '{fssc_pkg::PRIM_LINE_LOOP, 2, 2, 3}, '{fssc_pkg::PRIM_LINE_LOOP, 5, 5, 1},
    '{fssc_pkg::PRIM_LINE_STRIP, 2, 2, 3}, '{fssc_pkg::PRIM_TRIS, 2, 4, 6},
    '{fssc_pkg::PRIM_TRI_STRIP, 2, 2, 4}, '{fssc_pkg::PRIM_TRI_FAN, 2, 3, 4},
    '{fssc_pkg::PRIM_QUADS, 2, 5, 8}, '{fssc_pkg::PRIM_QUAD_STRIP, 2, 3, 6},
    '{fssc_pkg::PRIM_POLYGON, 1, 1, 1}, '{fssc_pkg::PRIM_LINES_ADJ, 2, 6, 7},
    '{fssc_pkg::PRIM_LSTRIP_ADJ, 2, 3, 4}, '{fssc_pkg::PRIM_TRIS_ADJ, 2, 7, 11},
    '{fssc_pkg::PRIM_TSTRIP_ADJ, 2, 3, 7}, '{fssc_pkg::PRIM_POINT, 5, 5, 5}};

  always #12.5 I_CLK = ~I_CLK;

  fssc_top uut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_VALID(I_VALID), .I_PRIM(I_PRIM),
    .O_READY(O_READY), .O_VALID(O_VALID), .O_RESULT(O_RESULT), .I_READY(I_READY));
  fssc_sink sink (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_valid(O_VALID), .i_result(O_RESULT),
    .o_ready(I_READY), .i_stall(stall), .o_last(res), .o_got(got));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("Mismatches %0d, checks %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_idx(input logic [15:0] g, input logic [15:0] e);
    cmp_data({16'h0000, g}, {16'h0000, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_WR    <= 1'b1;
    I_ADDR  <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge I_CLK);
    I_RD   <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    cmp_data(O_RDATA, e);
  endtask
  // Offer one edge, hold it until taken, then wait for the sink
  task automatic send(input fssc_pkg::fssc_prim_t t, input logic [15:0] i,
      input logic [1:0] nv, input fssc_pkg::fssc_vec_t a, input fssc_pkg::fssc_vec_t b,
      input fssc_pkg::fssc_vec_t e, input logic [15:0] d);
    int k;
    @(posedge I_CLK);
    I_VALID <= 1'b1;
    I_PRIM  <= '{prim: t, index: i, count: 16'h0005, nverts: nv, clip_a: a, clip_b: b,
                 eye_a: e, eye_b: e, dist_a: {112'h0, d}, dist_b: '0};
    for (k = 0; k < 40; k++) begin
      @(negedge I_CLK);
      if (O_READY === 1'b1) break;
    end
    @(posedge I_CLK);
    I_VALID <= 1'b0;
    for (k = 0; k < 40 && got !== 1'b1; k++) begin
      @(posedge I_CLK);
      #1;
    end
    if (got !== 1'b1) begin
      miscompares++;
      results();
    end
  endtask
  task automatic clip(input logic [31:0] md, input logic [1:0] nv, input fssc_pkg::fssc_vec_t a,
      input fssc_pkg::fssc_vec_t b, input fssc_pkg::fssc_vec_t e, input logic [15:0] d,
      input fssc_pkg::fssc_outcome_t ex);
    wr(fssc_pkg::ADDR_MODE, md);
    send(nv == 2'h1 ? fssc_pkg::PRIM_POINT : fssc_pkg::PRIM_LINES, 16'h0001, nv, a, b, e, d);
    cmp_idx({14'h0000, res.outcome}, {14'h0000, ex});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge I_CLK);
    cmp_idx({13'h0000, O_VALID, O_READY, |O_RDATA}, 16'h0000);
    I_RST_N <= 1'b1;
    rd(fssc_pkg::ADDR_MODE, 32'h00000002);
    rd(fssc_pkg::ADDR_ENABLE, 32'h00000000);
    rd(fssc_pkg::ADDR_COEF0, 32'h00000000);
    rd(fssc_pkg::ADDR_STATUS, 32'h00000001);
    rd(4'h3, 32'h00000000);
    wr(fssc_pkg::ADDR_SELECT, 32'h00000003);
    wr(fssc_pkg::ADDR_COEF3, 32'h00000123);
    rd(fssc_pkg::ADDR_COEF3, 32'h00000123);
    // Provoking index table, both rules per row
    for (int r = 0; r < 16; r++) begin
      for (int m = 0; m < 2; m++) begin
        wr(fssc_pkg::ADDR_MODE, m ? 32'h00000002 : 32'h00000000);
        send(rows[r].p, rows[r].i, 2'h2, v_in, v_in, v_in, 16'h0000);
        cmp_idx(res.provoke_index, m ? rows[r].l : rows[r].f);
      end
    end
    // Clipping against a slow sink
    stall = 4'h3;
    clip(32'h0, 2'h1, v_in, v_in, v_in, 16'h0, fssc_pkg::CLIP_PASS);
    clip(32'h0, 2'h1, v_bnd, v_in, v_in, 16'h0, fssc_pkg::CLIP_PASS);
    clip(32'h0, 2'h1, v_out, v_in, v_in, 16'h0, fssc_pkg::CLIP_DISCARD);
    clip(32'h0, 2'h2, v_out, v_out, v_in, 16'h0, fssc_pkg::CLIP_DISCARD);
    clip(32'h0, 2'h2, v_in, v_out, v_in, 16'h0, fssc_pkg::CLIP_CUT);
    cmp_idx({13'h0000, res.cut_mask, res.new_edge_flag}, 16'h0005);
    clip(32'h0, 2'h1, v_z, v_in, v_in, 16'h0, fssc_pkg::CLIP_DISCARD);
    clip(32'h4, 2'h1, v_z, v_in, v_in, 16'h0, fssc_pkg::CLIP_PASS);
    wr(fssc_pkg::ADDR_SELECT, 32'h00000000);
    wr(fssc_pkg::ADDR_COEF0, 32'h00000001);
    clip(32'h0, 2'h1, v_in, v_in, v_neg, 16'h0, fssc_pkg::CLIP_PASS);
    wr(fssc_pkg::ADDR_ENABLE, 32'h00000001);
    clip(32'h0, 2'h1, v_in, v_in, v_neg, 16'h0, fssc_pkg::CLIP_DISCARD);
    clip(32'h10, 2'h1, v_in, v_in, v_neg, 16'h0, fssc_pkg::CLIP_DISCARD);
    wr(fssc_pkg::ADDR_COEF0, 32'h0000FFFF);
    clip(32'h0, 2'h1, v_in, v_in, v_neg, 16'h0, fssc_pkg::CLIP_PASS);
    clip(32'h30, 2'h1, v_in, v_in, v_in, 16'h8000, fssc_pkg::CLIP_DISCARD);
    // Shade rule and colour source
    clip(32'h0, 2'h1, v_in, v_in, v_in, 16'h0, fssc_pkg::CLIP_PASS);
    cmp_idx({13'h0000, res.flat, res.color_src}, 16'h0000);
    clip(32'h1, 2'h1, v_in, v_in, v_in, 16'h0, fssc_pkg::CLIP_PASS);
    cmp_idx({13'h0000, res.flat, res.color_src}, 16'h0004);
    clip(32'h9, 2'h1, v_in, v_in, v_in, 16'h0, fssc_pkg::CLIP_PASS);
    cmp_idx({13'h0000, res.flat, res.color_src}, 16'h0005);
    clip(32'h11, 2'h1, v_in, v_in, v_in, 16'h0, fssc_pkg::CLIP_PASS);
    cmp_idx({13'h0000, res.flat, res.color_src}, 16'h0006);
    // Second reset in mid-run clears state again
    @(posedge I_CLK);
    I_RST_N <= 1'b0;
    repeat (2) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    rd(fssc_pkg::ADDR_MODE, 32'h00000002);
    rd(fssc_pkg::ADDR_ENABLE, 32'h00000000);
    rd(fssc_pkg::ADDR_COEF0, 32'h00000000);
    results();
  end
endmodule
